/* File: hw/pt2_func_sel.sv */
// function selection of pins 1 and 0
`timescale 1ns/10ps
module pt2_func_sel #(
  parameter bit HAS_CNTDIR = 1'b1
) (
  input wire logic [7:0] dir,
  input wire logic cntDirSel,
  input wire logic intSel,
  input wire logic adcTrigEn,
  output logic [7:0] drive,
  output logic [7:0] generalIo
);
  always_comb begin
    drive = dir; // see [RQ3]
    generalIo = 8'hff;
    if (HAS_CNTDIR && cntDirSel) begin
      drive[1] = 1'b0; // see [RQ4]
      generalIo[1] = 1'b0;
    end
    if (intSel) begin
      drive[0] = 1'b0; // see [RQ5]
      generalIo[0] = 1'b0;
    end
    // adcTrigEn does not change pin direction
    if (adcTrigEn) begin
      drive[0] = drive[0];
    end
  end
endmodule // pt2_func_sel

/* File: hw/pt2_map.svh */
// register offsets, field positions and reset values of the port block
`ifndef PT2_MAP_SVH
`define PT2_MAP_SVH
`define PT2_ADDR_W 3
`define PT2_OFF_DATA 3'h0
`define PT2_OFF_DIR 3'h1
`define PT2_OFF_FUNC 3'h2
`define PT2_OFF_ODSEL 3'h3
`define PT2_OFF_MODE 3'h4
`define PT2_OFF_PIN 3'h5
`define PT2_RST_DATA 8'h00
`define PT2_RST_DIR 8'h00
`define PT2_RST_FUNC 8'hc0
`define PT2_RST_ODSEL 8'h00
`define PT2_FUNC_FIXED 8'hc0
`define PT2_BIT_INTSEL 0
`define PT2_BIT_CNTDIR 1
`define PT2_DIR_READ 8'hff
`endif

/* File: hw/pt2_pin_cell.sv */
// one port pin: driver selection and input capture
`timescale 1ns/10ps
module pt2_pin_cell (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic hiz,
  input wire logic driveOut,
  input wire logic openDrain,
  input wire logic dataBit,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic pinLevel
);
  // pin outputs registered; cleared to hi-z when hiz is set, otherwise frozen when not running
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end else if (ce) begin
      if (hiz) begin
        pinOut <= 1'b0; // see [RQ7]
        pinOe <= 1'b0;
      end else if (run) begin
        if (!driveOut) begin
          pinOut <= 1'b0; // see [RQ10]
          pinOe <= 1'b0;
        end else if (openDrain) begin
          pinOut <= 1'b0; // see [RQ2]
          pinOe <= !dataBit;
        end else begin
          pinOut <= dataBit; // see [RQ2]
          pinOe <= 1'b1;
        end
      end
    end
  end

  // input level sample, held outside running modes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinLevel <= 1'b0;
    end else if (ce && run) begin
      pinLevel <= pinIn;
    end
  end
endmodule // pt2_pin_cell

/* File: hw/pt2_pkg.sv */
// types of the port block
package pt2_pkg;
  typedef enum logic [2:0] {
    PT2_ACTIVE = 3'b000,
    PT2_SUBACTIVE = 3'b001,
    PT2_SLEEP = 3'b010,
    PT2_SUBSLEEP = 3'b011,
    PT2_WATCH = 3'b100,
    PT2_STANDBY = 3'b101
  } pt2_mode_t;
endpackage

/* File: hw/pt2_port.sv */
// 8-bit general-purpose port with open-drain select and function muxing
// Behaviour
// [RQ1] open-drain select register, eight bits, resets zero
// [RQ2] select 1 drives low only, 0 CMOS
// [RQ3] direction bit: 0 input, 1 output
// [RQ4] pin 1 count-direction input when selected
// [RQ5] pin 0 interrupt input, also A/D trigger
// [RQ6] software disables interrupt when using trigger
// [RQ7] reset/standby hi-z, sleep/watch hold, active runs
// [RQ8] read gives latch if output, else pin
// [RQ9] direction register write-only, reads all ones
// [RQ10] open-drain select ignored for input pins
`timescale 1ns/10ps
`include "pt2_map.svh"
module pt2_port #(
  parameter bit HAS_CNTDIR = 1'b1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [`PT2_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [2:0] powerMode,
  input wire logic adcTrigEnable,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  output logic countDirection,
  output logic extInterruptIn,
  output logic adcExternalTrigger
);
  logic [7:0] portDataLatch;
  logic [7:0] portDirectionCtrl;
  logic [7:0] pinFunctionReg;
  logic [7:0] portOpenDrainSelect;
  logic [7:0] drive;
  logic [7:0] generalIo;
  logic [7:0] pinLevel;
  logic [7:0] readView;
  logic run;
  logic hiz;
  logic cntDirSel;
  logic intSel;

  assign cntDirSel = HAS_CNTDIR ? pinFunctionReg[`PT2_BIT_CNTDIR] : 1'b0;
  assign intSel = pinFunctionReg[`PT2_BIT_INTSEL];

  // power mode decode
  always_comb begin
    run = 1'b0;
    hiz = 1'b0;
    case (pt2_pkg::pt2_mode_t'(powerMode))
      pt2_pkg::PT2_ACTIVE: run = 1'b1; // see [RQ7]
      pt2_pkg::PT2_SUBACTIVE: run = 1'b1;
      pt2_pkg::PT2_SLEEP: run = 1'b0;
      pt2_pkg::PT2_SUBSLEEP: run = 1'b0;
      pt2_pkg::PT2_WATCH: run = 1'b0;
      pt2_pkg::PT2_STANDBY: hiz = 1'b1; // see [RQ7]
      default: hiz = 1'b1;
    endcase
  end

  // data latch
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portDataLatch <= `PT2_RST_DATA;
    end else if (ce && regWr && regAddr == `PT2_OFF_DATA) begin
      portDataLatch <= regWdata;
    end
  end

  // direction control
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portDirectionCtrl <= `PT2_RST_DIR;
    end else if (ce && regWr && regAddr == `PT2_OFF_DIR) begin
      portDirectionCtrl <= regWdata; // see [RQ3]
    end
  end

  // pin function register, fixed upper bits
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinFunctionReg <= `PT2_RST_FUNC;
    end else if (ce && regWr && regAddr == `PT2_OFF_FUNC) begin
      pinFunctionReg <= regWdata | `PT2_FUNC_FIXED;
    end
  end

  // open-drain select
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portOpenDrainSelect <= `PT2_RST_ODSEL; // see [RQ1]
    end else if (ce && regWr && regAddr == `PT2_OFF_ODSEL) begin
      portOpenDrainSelect <= regWdata; // see [RQ1]
    end
  end

  pt2_func_sel #(
    .HAS_CNTDIR(HAS_CNTDIR)
  ) u_func (
    .dir(portDirectionCtrl),
    .cntDirSel(cntDirSel),
    .intSel(intSel),
    .adcTrigEn(adcTrigEnable),
    .drive(drive),
    .generalIo(generalIo)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      pt2_pin_cell u_cell (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .run(run),
        .hiz(hiz),
        .driveOut(drive[gi]),
        .openDrain(portOpenDrainSelect[gi]),
        .dataBit(portDataLatch[gi]),
        .pinIn(pinIn[gi]),
        .pinOut(pinOut[gi]),
        .pinOe(pinOe[gi]),
        .pinLevel(pinLevel[gi])
      );
    end
  endgenerate

  // latch where output, pin where input
  assign readView = (portDirectionCtrl & generalIo & portDataLatch) |
                    (~(portDirectionCtrl & generalIo) & pinLevel); // see [RQ8]

  // read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (ce) begin
      if (regRd) begin
        case (regAddr)
          `PT2_OFF_DATA: regRdata <= readView; // see [RQ8]
          `PT2_OFF_DIR: regRdata <= `PT2_DIR_READ; // see [RQ9]
          `PT2_OFF_FUNC: regRdata <= pinFunctionReg;
          `PT2_OFF_ODSEL: regRdata <= portOpenDrainSelect;
          `PT2_OFF_MODE: regRdata <= {5'h00, powerMode};
          `PT2_OFF_PIN: regRdata <= pinLevel;
          default: regRdata <= 8'h00;
        endcase
      end else begin
        regRdata <= 8'h00;
      end
    end
  end

  // dedicated input functions, routed from sampled pins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      countDirection <= 1'b0;
      extInterruptIn <= 1'b0;
      adcExternalTrigger <= 1'b0;
    end else if (ce) begin
      countDirection <= cntDirSel & pinLevel[1]; // see [RQ4]
      extInterruptIn <= intSel & pinLevel[0]; // see [RQ5]
      adcExternalTrigger <= intSel & adcTrigEnable & pinLevel[0]; // see [RQ5]
    end
  end
endmodule // pt2_port

/* File: verification/pt2_board.sv */
// board wiring of the port pins
`timescale 1ns/10ps
module pt2_board (
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] ext,
  output logic [7:0] pinIn
);
  // driven pins win over the board level
  assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
endmodule // pt2_board

/* File: verification/pt2_chk_asserts.sv */
// assertions of the port block
`timescale 1ns/10ps
module pt2_chk #(
  parameter bit HAS_CNTDIR = 1'b1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic [2:0] powerMode,
  input wire logic adcTrigEnable,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic countDirection,
  input wire logic extInterruptIn,
  input wire logic adcExternalTrigger
);
  logic [7:0] odsel;
  logic [1:0] func;
  logic live;
  assign live = powerMode < 3'h2;
  // mirror of the select registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      odsel <= 8'h00;
      func <= 2'b00;
    end else if (ce && regWr && regAddr == 3'h3) begin
      odsel <= regWdata;
    end else if (ce && regWr && regAddr == 3'h2) begin
      func <= regWdata[1:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_rd(logic [2:0] a);
    regRd && regAddr == a;
  endsequence
  a_reset_hiz: assert property ($rose(nrst) |-> pinOe == 8'h00) else $error("reset");
  a_odsel_read: assert property (s_rd(3'h3) |=> regRdata == odsel) else $error("odsel");
  a_dir_ones: assert property (s_rd(3'h1) |=> regRdata == 8'hff) else $error("dir");
  a_od_low: assert property ((pinOut & odsel & $past(odsel)) == 8'h00) else $error("od");
  a_standby_hiz: assert property ((powerMode == 3'h5) [*3] |-> pinOe == 8'h00)
    else $error("standby");
  a_cnt_follow: assert property ((live && HAS_CNTDIR && func[1]) [*3] |->
    countDirection == $past(pinIn[1], 2)) else $error("cnt");
  a_irq_follow: assert property ((live && func[0]) [*3] |->
    extInterruptIn == $past(pinIn[0], 2)) else $error("irq");
  a_trig_gate: assert property ((!func[0] || !adcTrigEnable) [*3] |->
    !adcExternalTrigger) else $error("trig");
endmodule // pt2_chk
bind pt2_port pt2_chk #(.HAS_CNTDIR(HAS_CNTDIR)) u_pt2_chk (
  .mclk(mclk),
  .nrst(nrst),
  .ce(ce),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWr(regWr),
  .regRd(regRd),
  .regRdata(regRdata),
  .powerMode(powerMode),
  .adcTrigEnable(adcTrigEnable),
  .pinIn(pinIn),
  .pinOut(pinOut),
  .pinOe(pinOe),
  .countDirection(countDirection),
  .extInterruptIn(extInterruptIn),
  .adcExternalTrigger(adcExternalTrigger)
);

/* File: verification/tb.sv */
// testbench of the port block
`timescale 1ns/10ps
module tb;
  logic mclk, nrst, ce, regWr, regRd, adcTrigEnable, countDirection, extInterruptIn, adcExternalTrigger;
  logic [2:0] regAddr, powerMode;
  logic [7:0] regWdata, regRdata, pinIn, pinOut, pinOe, ext;
  int fails = 0, check_count = 0, cyc = 0;
  pt2_port u_pt2_port (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .powerMode(powerMode),
    .adcTrigEnable(adcTrigEnable),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .countDirection(countDirection),
    .extInterruptIn(extInterruptIn),
    .adcExternalTrigger(adcExternalTrigger)
  );
  pt2_board u_pt2_board (
    .pinOut(pinOut),
    .pinOe(pinOe),
    .ext(ext),
    .pinIn(pinIn)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task pins(input logic [7:0] oe, input logic [7:0] out);
    repeat (4) @(posedge mclk);
    #1 chk(pinOe, oe);
    chk(pinOut & oe, out);
  endtask
  task wrap_up;
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    {nrst, regWr, regRd, adcTrigEnable, regAddr, regWdata, powerMode} = '0;
    ce = 1'b1;
    ext = 8'h3c;
    repeat (5) @(posedge mclk);
    chk(pinOe, 8'h00);
    nrst <= 1'b1;
    rd(3'h3, 8'h00);
    rd(3'h1, 8'hff);
    rd(3'h2, 8'hc0);
    rd(3'h6, 8'h00);
    wr(3'h3, 8'ha5);
    rd(3'h3, 8'ha5);
    wr(3'h0, 8'h5a);
    wr(3'h3, 8'h0f);
    wr(3'h1, 8'hff);
    pins(8'hf5, 8'h50);
    rd(3'h0, 8'h5a);
    wr(3'h1, 8'h00);
    pins(8'h00, 8'h00);
    rd(3'h0, 8'h3c);
    wr(3'h1, 8'h03);
    wr(3'h2, 8'h03);
    ext <= 8'h02;
    pins(8'h00, 8'h00);
    chk(countDirection, 8'h01);
    chk(extInterruptIn, 8'h00);
    rd(3'h5, 8'h02);
    @(posedge mclk);
    adcTrigEnable <= 1'b1;
    ext <= 8'h01;
    pins(8'h00, 8'h00);
    chk({extInterruptIn, adcExternalTrigger, countDirection}, 8'h06);
    rd(3'h0, 8'h01);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'hff);
    wr(3'h1, 8'hff);
    pins(8'hff, 8'hff);
    for (int m = 2; m < 5; m++) begin
      @(posedge mclk);
      powerMode <= m[2:0];
      wr(3'h0, 8'h00);
      pins(8'hff, 8'hff);
      rd(3'h4, {5'h00, m[2:0]});
      @(posedge mclk);
      powerMode <= 3'h0;
      pins(8'hff, 8'h00);
      wr(3'h0, 8'hff);
    end
    ce <= 1'b0;
    wr(3'h3, 8'hff);
    ce <= 1'b1;
    rd(3'h3, 8'h00);
    @(posedge mclk);
    powerMode <= 3'h5;
    pins(8'h00, 8'h00);
    wrap_up;
  end
endmodule // tb
